// [include/ifd_pkg.sv]
// package: field layout, class codes and timing constants of the decoder
package ifd_pkg;

  // ***********************************************************************
  // word layout
  // ***********************************************************************
  localparam int WORD_W      = 14;
  localparam int FILE_W      = 7;
  localparam int BIT_W       = 3;
  localparam int LIT8_W      = 8;
  localparam int LIT11_W     = 11;
  localparam int FILE_LSB    = 0;
  localparam int DEST_POS    = 7;
  localparam int BITSEL_LSB  = 7;
  localparam int CLASS_MSB   = 13;
  localparam int CLASS_LSB   = 12;
  localparam int BOP_MSB     = 11;
  localparam int BOP_LSB     = 10;
  localparam int SKIPTEST_MSB = 11;
  localparam int BYTEOP_MSB  = 11;
  localparam int BYTEOP_LSB  = 8;
  localparam int LIT_OP_MSB  = 11;
  localparam int LIT_OP_LSB  = 8;
  localparam int CALLGO_POS  = 11;

  // class field codes
  localparam logic [1:0] CLS_BYTE = 2'h0;
  localparam logic [1:0] CLS_BIT  = 2'h1;
  localparam logic [1:0] CLS_JUMP = 2'h2;
  localparam logic [1:0] CLS_LIT  = 2'h3;

  // bit-class sub-codes: clear, set, test-clear-skip, test-set-skip
  localparam logic [1:0] BOP_TSTC = 2'h2;
  localparam logic [1:0] BOP_TSTS = 2'h3;

  // byte-class sub-codes that may skip (decrement/increment and skip)
  localparam logic [3:0] BYOP_DECSKIP = 4'hb;
  localparam logic [3:0] BYOP_INCSKIP = 4'hf;

  // byte-class zero-upper group: return family and misc control
  localparam logic [3:0]  BYOP_MISC   = 4'h0;
  localparam logic [13:0] WORD_RETURN = 14'h0008;
  localparam logic [13:0] WORD_RETFIE = 14'h0009;

  // literal-class: return with literal uses upper nibble 01xx
  localparam logic [1:0] LITOP_RETLW = 2'h1;

  // ***********************************************************************
  // timing
  // ***********************************************************************
  localparam int OSC_PER_CYCLE = 4;
  localparam int CLK_MHZ       = 100;
  localparam int CLK_PERIOD_NS = 1000 / CLK_MHZ;

  typedef enum logic [1:0] {
    IFD_Q1 = 2'b00,
    IFD_Q2 = 2'b01,
    IFD_Q3 = 2'b11,
    IFD_Q4 = 2'b10
  } ifd_phase_t;

  typedef enum logic [1:0] {
    IFD_CLASS_BYTE = 2'h0,
    IFD_CLASS_BIT  = 2'h1,
    IFD_CLASS_LIT  = 2'h2
  } ifd_class_t;

endpackage : ifd_pkg

// [design/ifd_phase_gen.sv]
// four-phase generator splitting the clock into instruction cycles
`timescale 1ns/1ps
`default_nettype none
module ifd_phase_gen
  import ifd_pkg::*;
(
  // clock and reset
  input  wire logic       clock,
  input  wire logic       sys_rst,
  // phase outputs
  output ifd_phase_t      phase,
  output logic            cycle_start,
  output logic            cycle_end
);

  ifd_phase_t phase_reg;
  ifd_phase_t phase_next;

  // ***********************************************************************
  // phase sequencer
  // ***********************************************************************
  always_comb begin
    case (phase_reg)
      IFD_Q1:  phase_next = IFD_Q2;
      IFD_Q2:  phase_next = IFD_Q3;
      IFD_Q3:  phase_next = IFD_Q4;
      IFD_Q4:  phase_next = IFD_Q1;
      default: phase_next = IFD_Q1;
    endcase
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      phase_reg <= IFD_Q1;
    end else begin
      phase_reg <= phase_next;
    end
  end

  assign phase       = phase_reg;
  assign cycle_start = (phase_reg == IFD_Q1);
  assign cycle_end   = (phase_reg == IFD_Q4);

endmodule : ifd_phase_gen
`default_nettype wire

// [design/ifd_decoder.sv]
// instruction field decoder with cycle sequencing
`timescale 1ns/1ps
`default_nettype none

module ifd_decoder
  import ifd_pkg::*;
(
  // clock and reset
  input  wire logic                 clock,
  input  wire logic                 sys_rst,
  // program memory side
  input  wire logic [WORD_W-1:0]    instr_word,
  input  wire logic                 instr_valid,
  // datapath feedback
  input  wire logic                 test_true,
  input  wire logic                 ptr_write,
  // phase
  output ifd_phase_t                phase,
  output logic                      cycle_start,
  output logic                      cycle_end,
  // decoded fields
  output ifd_class_t                instr_class,
  output logic [WORD_W-1:0]         opcode_word,
  output logic [FILE_W-1:0]         file_addr,
  output logic                      dest_file,
  output logic                      dest_acc,
  output logic [BIT_W-1:0]          bit_sel,
  output logic [7:0]                bit_mask,
  output logic [LIT8_W-1:0]         literal8,
  output logic [LIT11_W-1:0]        literal11,
  output logic                      lit_is_long,
  output logic                      is_cond_test,
  output logic                      is_branch,
  // sequencing
  output logic                      exec_valid,
  output logic                      flush_nop,
  output logic                      load_pointer,
  output logic                      fetch_next
);

  // ***********************************************************************
  // phase generator
  // ***********************************************************************
  ifd_phase_gen u_phase (
    .clock       (clock),
    .sys_rst     (sys_rst),
    .phase       (phase),
    .cycle_start (cycle_start),
    .cycle_end   (cycle_end)
  );

  // ***********************************************************************
  // instruction latch, taken in the last phase (Q4) of each cycle
  // ***********************************************************************
  // the word stands a whole cycle while the next one is fetched
  logic [WORD_W-1:0] ir_reg;
  logic              ir_valid_reg;
  logic              flush_reg;
  logic              flush_next;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      ir_reg       <= 14'h0000;
      ir_valid_reg <= 1'b0;
    end else if (cycle_end) begin
      ir_reg       <= instr_word;
      ir_valid_reg <= instr_valid;
    end
  end

  // ***********************************************************************
  // combinational class and field decode
  // ***********************************************************************
  logic [1:0]  cls_f;
  logic [1:0]  bop_f;
  logic [3:0]  byop_f;
  ifd_class_t  cls_d;
  logic        cond_d;
  logic        branch_d;
  logic        long_d;

  assign cls_f  = ir_reg[CLASS_MSB:CLASS_LSB];
  assign bop_f  = ir_reg[BOP_MSB:BOP_LSB];
  assign byop_f = ir_reg[BYTEOP_MSB:BYTEOP_LSB];

  always_comb begin
    cls_d    = IFD_CLASS_LIT;
    cond_d   = 1'b0;
    branch_d = 1'b0;
    long_d   = 1'b0;
    case (cls_f)
      CLS_BYTE: begin
        cls_d  = IFD_CLASS_BYTE;
        cond_d = (byop_f == BYOP_DECSKIP) || (byop_f == BYOP_INCSKIP);
        // return family has no operand; only exact words branch
        branch_d = (ir_reg == WORD_RETURN) || (ir_reg == WORD_RETFIE);
      end
      CLS_BIT: begin
        cls_d  = IFD_CLASS_BIT;
        cond_d = (bop_f == BOP_TSTC) || (bop_f == BOP_TSTS);
      end
      CLS_JUMP: begin
        // call and goto both carry the long literal
        cls_d    = IFD_CLASS_LIT;
        long_d   = 1'b1;
        branch_d = 1'b1;
      end
      CLS_LIT: begin
        cls_d    = IFD_CLASS_LIT;
        // low bits of the sub-code are don't-care for this group
        branch_d = (ir_reg[LIT_OP_MSB:LIT_OP_MSB-1] == LITOP_RETLW);
      end
      default: begin
        cls_d = IFD_CLASS_LIT;
      end
    endcase
  end

  // ***********************************************************************
  // bit mask, one compare per bit of the addressed byte
  // ***********************************************************************
  logic [BIT_W-1:0] bsel_f;
  logic [7:0]       mask_d;

  assign bsel_f = ir_reg[BITSEL_LSB +: BIT_W];

  for (genvar gi = 0; gi < 8; gi++) begin : g_mask
    assign mask_d[gi] = (bsel_f == BIT_W'(gi));
  end

  // ***********************************************************************
  // registered field outputs
  // ***********************************************************************
  // fields of a flushed word still update; exec_valid says whether to use them
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      instr_class  <= IFD_CLASS_BYTE;
      opcode_word  <= 14'h0000;
      file_addr    <= 7'h00;
      dest_file    <= 1'b0;
      dest_acc     <= 1'b0;
      bit_sel      <= 3'h0;
      bit_mask     <= 8'h00;
      literal8     <= 8'h00;
      literal11    <= 11'h000;
      lit_is_long  <= 1'b0;
      is_cond_test <= 1'b0;
      is_branch    <= 1'b0;
    end else if (cycle_start) begin
      instr_class  <= cls_d;
      opcode_word  <= ir_reg;
      file_addr    <= ir_reg[FILE_LSB +: FILE_W];
      dest_file    <= (cls_d == IFD_CLASS_BYTE) && ir_reg[DEST_POS];
      dest_acc     <= (cls_d == IFD_CLASS_BYTE) && !ir_reg[DEST_POS];
      bit_sel      <= bsel_f;
      bit_mask     <= mask_d;
      literal8     <= ir_reg[LIT8_W-1:0];
      literal11    <= ir_reg[LIT11_W-1:0];
      lit_is_long  <= long_d;
      is_cond_test <= cond_d;
      is_branch    <= branch_d;
    end
  end

  // ***********************************************************************
  // cycle sequencing: skip or jump makes the next cycle a nop
  // ***********************************************************************
  logic exec_now;

  // a flushed cycle executes nothing even though a word was fetched
  assign exec_now = ir_valid_reg && !flush_reg;

  // a taken skip only drops the next word; the pointer still steps by one,
  // so only a jump or a pointer write asks for a new load
  logic skip_only;

  assign skip_only = is_cond_test && test_true && !is_branch && !ptr_write;

  always_comb begin
    flush_next = 1'b0;
    if (exec_now) begin
      flush_next = is_branch || (is_cond_test && test_true)
                   || ptr_write;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      flush_reg <= 1'b0;
    end else if (cycle_end) begin
      flush_reg <= flush_next;
    end
  end

  // ***********************************************************************
  // sequencing outputs
  // ***********************************************************************
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      exec_valid   <= 1'b0;
      flush_nop    <= 1'b0;
      load_pointer <= 1'b0;
    end else begin
      exec_valid   <= exec_now && !cycle_end;
      flush_nop    <= ir_valid_reg && flush_reg && !cycle_end;
      load_pointer <= cycle_end && flush_next && !skip_only;
    end
  end

  // fetch of the following word overlaps execution of this one
  assign fetch_next = cycle_end;

endmodule : ifd_decoder
`default_nettype wire

// [bench/ifd_decoder_props.sv]
// checker: cycle timing and field relations at the decoder ports
`timescale 1ns/1ps
`default_nettype none
module ifd_decoder_props
  import ifd_pkg::*;
(
  // clock and reset
  input wire logic              clock,
  input wire logic              sys_rst,
  // datapath feedback and phase
  input wire logic              test_true,
  input wire logic              ptr_write,
  input wire ifd_phase_t        phase,
  input wire logic              cycle_start,
  input wire logic              cycle_end,
  // decoded fields
  input wire ifd_class_t        instr_class,
  input wire logic [WORD_W-1:0] opcode_word,
  input wire logic [FILE_W-1:0] file_addr,
  input wire logic              dest_file,
  input wire logic [BIT_W-1:0]  bit_sel,
  input wire logic [7:0]        bit_mask,
  input wire logic [LIT8_W-1:0] literal8,
  input wire logic              is_cond_test,
  input wire logic              is_branch,
  // sequencing
  input wire logic              exec_valid,
  input wire logic              flush_nop,
  input wire logic              load_pointer
);
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  AST_CYCLE_FOUR: assert property (
    cycle_start |=> !cycle_start [*3] ##1 cycle_start)
    else $error("instruction cycle is not four clocks");
  AST_PHASE: assert property (
    (cycle_start == (phase == IFD_Q1)) && (cycle_end == (phase == IFD_Q4)))
    else $error("phase strobes do not match the phase");
  AST_CLASS: assert property (
    instr_class == (opcode_word[13] ? IFD_CLASS_LIT :
                    (opcode_word[12] ? IFD_CLASS_BIT : IFD_CLASS_BYTE)))
    else $error("class does not follow the word");
  AST_FILE: assert property (
    file_addr == opcode_word[6:0])
    else $error("file address does not follow the word");
  // reset leaves fields cleared, so only executing words are judged
  AST_DEST: assert property (
    exec_valid |-> dest_file == (instr_class == IFD_CLASS_BYTE
                                 && opcode_word[7]))
    else $error("destination select wrong");
  AST_MASK: assert property (
    exec_valid |-> bit_sel == opcode_word[9:7]
                   && bit_mask == 8'h01 << bit_sel)
    else $error("bit select or mask wrong");
  AST_LIT: assert property (
    exec_valid |-> literal8 == opcode_word[7:0])
    else $error("literal field wrong");
  AST_EXCL: assert property (
    !(exec_valid && flush_nop))
    else $error("flushed cycle also executes");
  AST_FLUSH: assert property (
    cycle_start ##3 (exec_valid && (is_branch || ptr_write
                                    || (is_cond_test && test_true)))
    |=> ##1 flush_nop)
    else $error("two-cycle word not followed by a nop");
  AST_LOAD: assert property (
    cycle_end && exec_valid && (is_branch || ptr_write) |=> load_pointer)
    else $error("jump or pointer write gave no pointer load");
  AST_LOAD_Q1: assert property (
    load_pointer |-> cycle_start)
    else $error("pointer load outside the first phase");
endmodule : ifd_decoder_props
bind ifd_decoder ifd_decoder_props i_props (
  .clock        (clock),
  .sys_rst      (sys_rst),
  .test_true    (test_true),
  .ptr_write    (ptr_write),
  .phase        (phase),
  .cycle_start  (cycle_start),
  .cycle_end    (cycle_end),
  .instr_class  (instr_class),
  .opcode_word  (opcode_word),
  .file_addr    (file_addr),
  .dest_file    (dest_file),
  .bit_sel      (bit_sel),
  .bit_mask     (bit_mask),
  .literal8     (literal8),
  .is_cond_test (is_cond_test),
  .is_branch    (is_branch),
  .exec_valid   (exec_valid),
  .flush_nop    (flush_nop),
  .load_pointer (load_pointer)
);
`default_nettype wire

// [bench/ifd_prog_mem.sv]
// program memory model presenting one word per fetch
`timescale 1ns/1ps
`default_nettype none
module ifd_prog_mem
  import ifd_pkg::*;
(
  // clock and fetch strobe
  input  wire logic              clock,
  input  wire logic              fetch_next,
  // word the bench wants fetched next
  input  wire logic [WORD_W-1:0] word_in,
  input  wire logic              valid_in,
  // program memory bus
  output logic [WORD_W-1:0]      instr_word,
  output logic                   instr_valid
);
  logic [WORD_W-1:0] last_reg;
  always_ff @(posedge clock) begin
    if (fetch_next) begin
      last_reg <= word_in;
    end
  end
  // outside a fetch the bus shows garbage, so late sampling is caught
  assign instr_word  = fetch_next ? word_in : ~last_reg;
  assign instr_valid = fetch_next & valid_in;
endmodule : ifd_prog_mem
`default_nettype wire

// [bench/ifd_decoder_tb.sv]
// testbench: field decoding and cycle sequencing of the decoder
`timescale 1ns/1ps
`default_nettype none
module ifd_decoder_tb;
  import ifd_pkg::*;
  logic               clock, sys_rst, valid_in, test_true, ptr_write;
  logic [WORD_W-1:0]  word_in, instr_word;
  logic               instr_valid, fetch_next, exec_valid, flush_nop;
  logic               dest_file, dest_acc, lit_is_long;
  logic               is_cond_test, is_branch, load_pointer;
  ifd_class_t         instr_class;
  logic [FILE_W-1:0]  file_addr;
  logic [BIT_W-1:0]   bit_sel;
  logic [7:0]         bit_mask;
  logic [LIT8_W-1:0]  literal8;
  logic [LIT11_W-1:0] literal11;
  int                 n_fail = 0, n_tests = 0, n_load = 0;
  ifd_decoder i_dut (
    .clock        (clock),
    .sys_rst      (sys_rst),
    .instr_word   (instr_word),
    .instr_valid  (instr_valid),
    .test_true    (test_true),
    .ptr_write    (ptr_write),
    .phase        (),
    .cycle_start  (),
    .cycle_end    (),
    .instr_class  (instr_class),
    .opcode_word  (),
    .file_addr    (file_addr),
    .dest_file    (dest_file),
    .dest_acc     (dest_acc),
    .bit_sel      (bit_sel),
    .bit_mask     (bit_mask),
    .literal8     (literal8),
    .literal11    (literal11),
    .lit_is_long  (lit_is_long),
    .is_cond_test (is_cond_test),
    .is_branch    (is_branch),
    .exec_valid   (exec_valid),
    .flush_nop    (flush_nop),
    .load_pointer (load_pointer),
    .fetch_next   (fetch_next)
  );
  ifd_prog_mem i_mem (
    .clock       (clock),
    .fetch_next  (fetch_next),
    .word_in     (word_in),
    .valid_in    (valid_in),
    .instr_word  (instr_word),
    .instr_valid (instr_valid)
  );
  // pointer loads are one-clock pulses, so they are counted as they pass
  always @(posedge clock) begin
    if (load_pointer === 1'b1) begin
      n_load++;
    end
  end
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : tally_and_finish
  // t and p answer for the word now executing; returns in Q3 of w's cycle
  task automatic step(input logic [WORD_W-1:0] w, input logic v, t, p);
    int n;
    n = 0;
    while (fetch_next !== 1'b1 && n < 20) begin
      @(posedge clock);
      #1 n++;
    end
    if (fetch_next !== 1'b1) begin
      n_fail++;
      tally_and_finish();
    end
    {word_in, valid_in, test_true, ptr_write} = {w, v, t, p};
    repeat (3) @(posedge clock);
    #1;
  endtask : step
  task automatic t_byte;
    logic [WORD_W-1:0] w;
    for (int i = 0; i < 3; i++) begin
      w = (i == 0) ? 14'h07a5 : (i == 1) ? 14'h0720 : 14'h07ff;
      step(w, 1'b1, 1'b0, 1'b0);
      chk("class", instr_class, IFD_CLASS_BYTE);
      chk("file", file_addr, w[6:0]);
      chk("dest_file", dest_file, w[7]);
      chk("dest_acc", dest_acc, !w[7]);
    end
    $display("test byte done");
  endtask : t_byte
  task automatic t_bit;
    for (int b = 0; b < 8; b++) begin
      step({2'h1, 2'h0, 3'(b), 7'h11}, 1'b1, 1'b0, 1'b0);
      chk("class", instr_class, IFD_CLASS_BIT);
      chk("bit_sel", bit_sel, b);
      chk("bit_mask", bit_mask, 8'h01 << b);
    end
    $display("test bit done");
  endtask : t_bit
  task automatic t_lit;
    logic [WORD_W-1:0] tbl [5];
    tbl = '{14'h30a5, 14'h33a5, 14'h34a5, 14'h37a5, 14'h25a5};
    for (int i = 0; i < 5; i++) begin
      step(tbl[i], 1'b1, 1'b0, 1'b0);
      chk("class", instr_class, IFD_CLASS_LIT);
      chk("lit8", literal8, 8'ha5);
      chk("lit11", literal11, tbl[i][10:0]);
      chk("long", lit_is_long, i == 4);
      chk("branch", is_branch, i >= 2);
    end
    $display("test literal done");
  endtask : t_lit
  task automatic t_skip;
    int n0;
    // the goto that ended the literal test loads the pointer here
    n0 = n_load;
    step(14'h0725, 1'b1, 1'b0, 1'b0);
    chk("load_jump", n_load - n0, 1);
    step(14'h1ca5, 1'b1, 1'b0, 1'b0);
    chk("cond", is_cond_test, 1'b1);
    chk("exec", exec_valid, 1'b1);
    n0 = n_load;
    step(14'h0725, 1'b1, 1'b1, 1'b0);
    chk("flush", flush_nop, 1'b1);
    chk("exec", exec_valid, 1'b0);
    chk("load_skip", n_load - n0, 0);
    step(14'h1ca5, 1'b1, 1'b0, 1'b0);
    chk("flush", flush_nop, 1'b0);
    chk("exec", exec_valid, 1'b1);
    step(14'h0725, 1'b1, 1'b0, 1'b0);
    chk("flush", flush_nop, 1'b0);
    n0 = n_load;
    step(14'h0725, 1'b1, 1'b0, 1'b1);
    chk("flush", flush_nop, 1'b1);
    chk("load_write", n_load - n0, 1);
    step(14'h0725, 1'b0, 1'b0, 1'b0);
    chk("exec", exec_valid, 1'b0);
    $display("test skip done");
  endtask : t_skip
  task automatic t_reset;
    sys_rst = 1'b1;
    repeat (2) @(posedge clock);
    #1;
    chk("rst_class", instr_class, IFD_CLASS_BYTE);
    chk("rst_exec", exec_valid, 1'b0);
    chk("rst_flush", flush_nop, 1'b0);
    chk("rst_lit11", literal11, 11'h000);
    sys_rst = 1'b0;
    step(14'h3e5a, 1'b1, 1'b0, 1'b0);
    chk("class", instr_class, IFD_CLASS_LIT);
    chk("lit8", literal8, 8'h5a);
    chk("exec", exec_valid, 1'b1);
    $display("test reset done");
  endtask : t_reset
  initial begin
    sys_rst = 1'b1;
    {word_in, valid_in, test_true, ptr_write} = '0;
    repeat (6) @(posedge clock);
    #1 sys_rst = 1'b0;
    t_byte();
    t_bit();
    t_lit();
    t_skip();
    t_reset();
    tally_and_finish();
  end
endmodule : ifd_decoder_tb
`default_nettype wire
